/* src/pdc_top.sv */
// clock synthesizer parameter word, lock flag and regulator level
`timescale 1ns/1ps
module pdc_top
  import pdc_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // serial control port, byte level
  input  wire logic        ctl_start_i,
  input  wire logic [15:0] ctl_addr_i,
  input  wire logic        ctl_wr_i,
  input  wire logic [7:0]  ctl_wdata_i,
  input  wire logic        ctl_rd_i,
  input  wire logic        ctl_end_i,
  output logic [7:0]       ctl_rdata_o,
  output logic             ctl_rvalid_o,
  // synthesizer loop
  input  wire logic        ref_tick_i,
  input  wire logic        fb_tick_i,
  input  wire logic        lock_detect_i,
  output pdc_cfg_s         synth_cfg_o,
  output logic             ref_div_tick_o,
  output logic [4:0]       fb_ratio_o,
  output logic [10:0]      out_mult_o,
  output logic [2:0]       core_div_o,
  // core regulator
  output logic [1:0]       core_supply_output_o
);

  // ==========================================================
  // declarations
  pdc_burst_e  bst_r;
  logic [15:0] ptr_r;
  logic [5:0]  mask_r;
  logic [47:0] stage_r;
  logic [47:0] param_r;
  logic        lock_r;
  logic [1:0]  lvl_r;
  logic [1:0]  pdiv_cnt_r;
  logic [15:0] ofs;
  logic [2:0]  idx;
  logic        in_param;
  logic        in_reg;
  logic        wr_ok;
  logic        rd_ok;
  logic        apply;
  logic        lock_set;
  logic [47:0] new_word;
  logic [47:0] read_word;
  logic [7:0]  read_byte;

  // ==========================================================
  // address decode on the burst pointer
  always_comb begin
    ofs      = 16'(ptr_r - PDC_ADDR_PARAM);
    idx      = ofs[2:0];
    in_param = (ptr_r >= PDC_ADDR_PARAM) && (ofs <= {13'h0000, PDC_PARAM_LAST});
    in_reg   = (ptr_r == PDC_ADDR_REG);
    wr_ok    = ctl_wr_i && !ctl_start_i && (bst_r == PDC_BST_ACTIVE);
    rd_ok    = ctl_rd_i && !ctl_start_i && !ctl_wr_i && (bst_r == PDC_BST_ACTIVE);
  end

  // full word only once every earlier byte came in this same burst
  assign apply    = wr_ok && in_param && (idx == PDC_PARAM_LAST)
                  && (&mask_r[4:0]);
  assign new_word = {stage_r[47:8], ctl_wdata_i} & PDC_PARAM_WMASK;

  // ==========================================================
  // burst state: a start opens, an end closes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bst_r <= PDC_BST_IDLE;
    end else if (ctl_start_i) begin
      bst_r <= PDC_BST_ACTIVE;
    end else if (ctl_end_i) begin
      bst_r <= PDC_BST_IDLE;
    end
  end

  // auto-incrementing byte pointer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr_r <= 16'h0000;
    end else if (ctl_start_i) begin
      ptr_r <= ctl_addr_i;
    end else if (wr_ok || rd_ok) begin
      ptr_r <= 16'(ptr_r + 16'h0001);
    end
  end

  // ==========================================================
  // staging of parameter bytes, first byte is the top one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stage_r <= PDC_PARAM_RST;
    end else if (wr_ok && in_param) begin
      stage_r[8 * (5 - idx) +: 8] <= ctl_wdata_i;
    end
  end

  // bytes seen in the current burst; forgotten when a burst ends
  always_ff @(posedge clk_i) begin
    if (rst_i || ctl_start_i || ctl_end_i || apply) begin
      mask_r <= PDC_MASK_NONE;
    end else if (wr_ok && in_param) begin
      mask_r[idx] <= 1'b1;
    end
  end

  // live parameter word, updated only on the final byte
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      param_r <= PDC_PARAM_RST & PDC_PARAM_WMASK;
    end else if (apply) begin
      param_r <= new_word;
    end
  end

  // ==========================================================
  // lock flag: set by a lock while running, dropped only when switched off
  assign lock_set = param_r[PDC_EN_BIT] && lock_detect_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_r <= PDC_LOCK_RST;
    end else if (lock_set) begin
      lock_r <= 1'b1;
    end else if (!param_r[PDC_EN_BIT]) begin
      lock_r <= 1'b0;
    end
  end

  // ==========================================================
  // regulator level, reserved bits dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lvl_r <= PDC_LVL_RST;
    end else if (wr_ok && in_reg) begin
      lvl_r <= ctl_wdata_i[PDC_LVL_MSB:PDC_LVL_LSB];
    end
  end

  assign core_supply_output_o = lvl_r;

  // ==========================================================
  // readback: lock flag merged into bit 1, unmapped bytes read zero
  always_comb begin
    read_word               = param_r;
    read_word[PDC_LOCK_BIT] = lock_r;
    read_byte               = 8'h00;
    if (in_param) begin
      read_byte = read_word[8 * (5 - idx) +: 8];
    end else if (in_reg) begin
      read_byte = {5'h00, lvl_r, 1'b0};
    end
  end

  // read data held until the next read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_rdata_o <= 8'h00;
    end else if (rd_ok) begin
      ctl_rdata_o <= read_byte;
    end
  end

  // one pulse per read byte
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_rvalid_o <= 1'b0;
    end else begin
      ctl_rvalid_o <= rd_ok;
    end
  end

  // ==========================================================
  // settings to the synthesizer
  assign synth_cfg_o = '{
    denom:     param_r[PDC_DEN_MSB:PDC_DEN_LSB],
    numer:     param_r[PDC_NUM_MSB:PDC_NUM_LSB],
    mult:      param_r[PDC_INT_MSB:PDC_INT_LSB],
    prediv:    param_r[PDC_DIV_MSB:PDC_DIV_LSB],
    frac_mode: param_r[PDC_TYPE_BIT],
    enable:    param_r[PDC_EN_BIT]
  };

  // output fixed at 1024 x base rate, core clock a quarter of it
  assign out_mult_o = PDC_OUT_MULT;
  assign core_div_o = PDC_CORE_DIV;

  // ==========================================================
  // reference predivider, one output strobe per X + 1 input strobes
  always_ff @(posedge clk_i) begin
    if (rst_i || !synth_cfg_o.enable) begin
      pdiv_cnt_r     <= 2'h0;
      ref_div_tick_o <= 1'b0;
    end else if (ref_tick_i) begin
      if (pdiv_cnt_r >= synth_cfg_o.prediv) begin
        pdiv_cnt_r     <= 2'h0;
        ref_div_tick_o <= 1'b1;
      end else begin
        pdiv_cnt_r     <= 2'(pdiv_cnt_r + 2'h1);
        ref_div_tick_o <= 1'b0;
      end
    end else begin
      ref_div_tick_o <= 1'b0;
    end
  end

  // ==========================================================
  // feedback ratio, fraction ignored in integer-only mode
  pdc_fb_ratio u_fb_ratio (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .fb_tick_i (fb_tick_i && synth_cfg_o.enable),
    .cfg_i     (synth_cfg_o),
    .ratio_o   (fb_ratio_o)
  );

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // denominator equals the staged top two bytes after apply
  property p_denom_apply;
    apply |=> synth_cfg_o.denom == $past(stage_r[47:32]);
  endproperty
  a_denom_apply: assert property (p_denom_apply) else $error("denominator not applied");

  // numerator equals the staged next two bytes after apply
  property p_numer_apply;
    apply |=> synth_cfg_o.numer == $past(stage_r[31:16]);
  endproperty
  a_numer_apply: assert property (p_numer_apply) else $error("numerator not applied");

  // bypass passes every reference strobe
  property p_prediv_bypass;
    (synth_cfg_o.enable && synth_cfg_o.prediv == PDC_DIV_NONE && ref_tick_i && !apply)
      |=> ref_div_tick_o;
  endproperty
  a_prediv_bypass: assert property (p_prediv_bypass) else $error("bypass lost a strobe");

  // divide by four: a strobe out only on the fourth input strobe
  property p_prediv_four;
    (synth_cfg_o.prediv == PDC_DIV_4 && ref_div_tick_o && $stable(synth_cfg_o))
      |-> $past(ref_tick_i) && pdiv_cnt_r == 2'h0 && $past(pdiv_cnt_r) == 2'h3;
  endproperty
  a_prediv_four: assert property (p_prediv_four) else $error("divide by four miscounted");

  // integer-only mode uses the bare multiplier
  property p_int_mode;
    (synth_cfg_o.enable && !synth_cfg_o.frac_mode && $stable(synth_cfg_o))
      |=> fb_ratio_o == {1'b0, $past(synth_cfg_o.mult)};
  endproperty
  a_int_mode: assert property (p_int_mode) else $error("integer ratio wrong");

  // fractional ratio is the multiplier or one above it
  property p_frac_ratio;
    (synth_cfg_o.enable && synth_cfg_o.frac_mode && fb_tick_i && !apply)
      |=> (fb_ratio_o == {1'b0, $past(synth_cfg_o.mult)})
       || (fb_ratio_o == 5'({1'b0, $past(synth_cfg_o.mult)} + 5'h01));
  endproperty
  a_frac_ratio: assert property (p_frac_ratio) else $error("fractional ratio wrong");

  // a write to the lock byte leaves the flag as it was
  property p_lock_ro;
    (wr_ok && in_param && idx == PDC_PARAM_LAST && synth_cfg_o.enable
      && ctl_wdata_i[PDC_EN_BIT] && !lock_set) |=> $stable(lock_r);
  endproperty
  a_lock_ro: assert property (p_lock_ro) else $error("write changed lock flag");

  // a lock while running shows within one cycle and in readback
  property p_lock_set;
    lock_set |=> lock_r ##0 read_word[PDC_LOCK_BIT];
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("lock not flagged");

  // once set, loss of lock for two cycles does not clear it
  property p_lock_sticky;
    (lock_r && synth_cfg_o.enable) ##1 (!lock_detect_i && synth_cfg_o.enable) [*2]
      |-> lock_r;
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("lock flag not sticky");

  // switched off means no reference strobe out and the count restarts
  property p_disable_quiet;
    !synth_cfg_o.enable |=> !ref_div_tick_o && pdiv_cnt_r == 2'h0;
  endproperty
  a_disable_quiet: assert property (p_disable_quiet) else $error("strobe while off");

  // a non-final byte never moves the live settings
  property p_partial_hold;
    (wr_ok && !apply) |=> $stable(synth_cfg_o);
  endproperty
  a_partial_hold: assert property (p_partial_hold) else $error("partial word applied");

  // main scenarios
  c_apply:     cover property (apply);
  c_carry:     cover property (synth_cfg_o.frac_mode
                               && fb_ratio_o == 5'({1'b0, synth_cfg_o.mult} + 5'h01));
  c_lock_held: cover property (lock_r && synth_cfg_o.enable && !lock_detect_i);
  c_read_lock: cover property (rd_ok && in_param && idx == PDC_PARAM_LAST);

endmodule : pdc_top

/* src/pdc_pkg.sv */
// constants and types for the clock synthesizer configuration block
package pdc_pkg;

  // ==========================================================
  // register addresses on the serial control port
  localparam logic [15:0] PDC_ADDR_REG    = 16'h4001;  // regulator level byte
  localparam logic [15:0] PDC_ADDR_PARAM  = 16'h4002;  // first byte of the parameter word
  localparam logic [2:0]  PDC_PARAM_LAST  = 3'h5;      // index of the final burst byte
  localparam logic [5:0]  PDC_MASK_NONE   = 6'h00;

  // ==========================================================
  // reset values
  localparam logic [1:0]  PDC_LVL_RST     = 2'h1;                // 1.4 V
  localparam logic [47:0] PDC_PARAM_RST   = 48'h0753_0287_1903;
  localparam logic [47:0] PDC_PARAM_WMASK = 48'hffff_ffff_7f01;  // writable bits
  localparam logic        PDC_LOCK_RST    = 1'b1;

  // ==========================================================
  // field positions in the parameter word
  localparam int PDC_DEN_MSB  = 47;
  localparam int PDC_DEN_LSB  = 32;
  localparam int PDC_NUM_MSB  = 31;
  localparam int PDC_NUM_LSB  = 16;
  localparam int PDC_INT_MSB  = 14;
  localparam int PDC_INT_LSB  = 11;
  localparam int PDC_DIV_MSB  = 10;
  localparam int PDC_DIV_LSB  = 9;
  localparam int PDC_TYPE_BIT = 8;
  localparam int PDC_LOCK_BIT = 1;
  localparam int PDC_EN_BIT   = 0;

  // field positions in the regulator byte
  localparam int PDC_LVL_MSB  = 2;
  localparam int PDC_LVL_LSB  = 1;

  // ==========================================================
  // predivider codes and fixed ratios
  localparam logic [1:0]  PDC_DIV_NONE  = 2'h0;
  localparam logic [1:0]  PDC_DIV_4     = 2'h3;
  localparam logic [10:0] PDC_OUT_MULT  = 11'h400;  // output = 1024 x base rate
  localparam logic [2:0]  PDC_CORE_DIV  = 3'h4;     // 1024 / 256 down to core clock

  // ==========================================================
  // configuration carried to the synthesizer
  typedef struct packed {
    logic [15:0] denom;
    logic [15:0] numer;
    logic [3:0]  mult;
    logic [1:0]  prediv;
    logic        frac_mode;
    logic        enable;
  } pdc_cfg_s;

  // control port burst state
  typedef enum logic [1:0] {
    PDC_BST_IDLE   = 2'b00,
    PDC_BST_ACTIVE = 2'b01
  } pdc_burst_e;

endpackage : pdc_pkg

/* src/pdc_fb_ratio.sv */
// feedback division ratio generator: integer part plus fractional carry
`timescale 1ns/1ps
module pdc_fb_ratio
  import pdc_pkg::*;
(
  // clock and reset
  input  wire logic     clk_i,
  input  wire logic     rst_i,
  // feedback cycle strobe and settings
  input  wire logic     fb_tick_i,
  input  wire pdc_cfg_s cfg_i,
  // ratio for the next feedback cycle
  output logic [4:0]    ratio_o
);

  // ==========================================================
  // fractional accumulator
  logic [16:0] acc_r;
  logic [16:0] sum;
  logic        carry;
  logic        frac_run;

  // running sum of the numerator, compared against the denominator
  always_comb begin
    frac_run = cfg_i.enable && cfg_i.frac_mode;
    sum      = 17'(acc_r + {1'b0, cfg_i.numer});
    carry    = frac_run && (cfg_i.denom != 16'h0000) && (sum >= {1'b0, cfg_i.denom});
  end

  // accumulator wraps modulo the denominator on each feedback cycle
  always_ff @(posedge clk_i) begin
    if (rst_i || !frac_run) begin
      acc_r <= 17'h0_0000;
    end else if (fb_tick_i) begin
      acc_r <= carry ? 17'(sum - {1'b0, cfg_i.denom}) : sum;
    end
  end

  // ==========================================================
  // ratio register: mult alone when integer-only or off, mult plus carry else
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ratio_o <= {1'b0, PDC_PARAM_RST[PDC_INT_MSB:PDC_INT_LSB]};
    end else if (!frac_run) begin
      ratio_o <= {1'b0, cfg_i.mult};
    end else if (fb_tick_i) begin
      ratio_o <= 5'({1'b0, cfg_i.mult} + {4'h0, carry});
    end
  end

endmodule : pdc_fb_ratio

/* verif/pdc_top_bench.sv */
// self-checking bench for the clock synthesizer configuration block
`timescale 1ns/1ps
module pdc_top_bench;
  import pdc_pkg::*;

  // ==========================================================
  // design signals
  logic        clk_i;
  logic        rst_i;
  logic        ctl_start_i;
  logic [15:0] ctl_addr_i;
  logic        ctl_wr_i;
  logic [7:0]  ctl_wdata_i;
  logic        ctl_rd_i;
  logic        ctl_end_i;
  logic [7:0]  ctl_rdata_o;
  logic        ctl_rvalid_o;
  logic        ref_tick_i;
  logic        fb_tick_i;
  logic        lock_detect_i;
  pdc_cfg_s    synth_cfg_o;
  logic        ref_div_tick_o;
  logic [4:0]  fb_ratio_o;
  logic [10:0] out_mult_o;
  logic [2:0]  core_div_o;
  logic [1:0]  core_supply_output_o;
  int          n_mismatch;
  int          num_checks;
  int          cyc;
  int          hits;

  pdc_top i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .ctl_start_i(ctl_start_i), .ctl_addr_i(ctl_addr_i),
    .ctl_wr_i(ctl_wr_i), .ctl_wdata_i(ctl_wdata_i), .ctl_rd_i(ctl_rd_i),
    .ctl_end_i(ctl_end_i), .ctl_rdata_o(ctl_rdata_o), .ctl_rvalid_o(ctl_rvalid_o),
    .ref_tick_i(ref_tick_i), .fb_tick_i(fb_tick_i), .lock_detect_i(lock_detect_i),
    .synth_cfg_o(synth_cfg_o), .ref_div_tick_o(ref_div_tick_o), .fb_ratio_o(fb_ratio_o),
    .out_mult_o(out_mult_o), .core_div_o(core_div_o),
    .core_supply_output_o(core_supply_output_o)
  );

  // ==========================================================
  // clock and hang guard
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // cut a hang short well beyond the expected run length
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      end_of_test();
    end
  end

  // ==========================================================
  // helpers
  task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // one burst: start, n back-to-back byte writes of the low n bytes of d, highest first, end
  task automatic wr_q(input logic [15:0] a, input int n, input logic [47:0] d);
    @(negedge clk_i);
    ctl_start_i = 1'b1;
    ctl_addr_i  = a;
    @(negedge clk_i);
    ctl_start_i = 1'b0;
    for (int i = 0; i < n; i++) begin
      ctl_wr_i    = 1'b1;
      ctl_wdata_i = d[8 * (n - 1 - i) +: 8];
      @(negedge clk_i);
    end
    ctl_wr_i  = 1'b0;
    ctl_end_i = 1'b1;
    @(negedge clk_i);
    ctl_end_i = 1'b0;
  endtask : wr_q

  // full six-byte parameter burst, high byte first
  task automatic wr_word(input logic [47:0] w);
    wr_q(PDC_ADDR_PARAM, 6, w);
  endtask : wr_word

  // one-byte read burst, answer one edge after the read pulse
  task automatic rd_chk(input string nm, input logic [15:0] a, input logic [7:0] e);
    @(negedge clk_i);
    ctl_start_i = 1'b1;
    ctl_addr_i  = a;
    @(negedge clk_i);
    ctl_start_i = 1'b0;
    ctl_rd_i    = 1'b1;
    @(negedge clk_i);
    chk({nm, " valid"}, 48'(ctl_rvalid_o), 48'h1);
    chk(nm, 48'(ctl_rdata_o), 48'(e));
    ctl_rd_i  = 1'b0;
    ctl_end_i = 1'b1;
    @(negedge clk_i);
    ctl_end_i = 1'b0;
  endtask : rd_chk

  // configuration fields against expected values
  task automatic cfg_chk(input logic [15:0] m, input logic [15:0] n, input logic [3:0] r,
                         input logic [1:0] x, input logic f, input logic en);
    chk("denom", 48'(synth_cfg_o.denom), 48'(m));
    chk("numer", 48'(synth_cfg_o.numer), 48'(n));
    chk("mult", 48'(synth_cfg_o.mult), 48'(r));
    chk("prediv", 48'(synth_cfg_o.prediv), 48'(x));
    chk("frac_mode", 48'(synth_cfg_o.frac_mode), 48'(f));
    chk("enable", 48'(synth_cfg_o.enable), 48'(en));
  endtask : cfg_chk

  task automatic end_of_test;
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test

  // ==========================================================
  // main sequence
  initial begin
    n_mismatch = 0;
    num_checks = 0;
    cyc = 0;
    rst_i = 1'b1;
    {ctl_start_i, ctl_wr_i, ctl_rd_i, ctl_end_i, ref_tick_i, fb_tick_i} = 6'h00;
    ctl_addr_i = 16'h0000;
    ctl_wdata_i = 8'h00;
    lock_detect_i = 1'b0;
    repeat (12) @(negedge clk_i);
    rst_i = 1'b0;
    // reset defaults of both registers
    cfg_chk(16'h0753, 16'h0287, 4'h3, 2'h0, 1'b1, 1'b1);
    chk("out_mult", 48'(out_mult_o), 48'h400);
    chk("supply", 48'(core_supply_output_o), 48'h1);
    rd_chk("lock byte", PDC_ADDR_PARAM + 16'h5, 8'h03);
    rd_chk("mid byte", PDC_ADDR_PARAM + 16'h4, 8'h19);
    rd_chk("regulator", PDC_ADDR_REG, 8'h02);
    // five bytes then end, then the last byte alone: nothing applies
    wr_q(PDC_ADDR_PARAM, 5, 48'h11_2233_442d);
    cfg_chk(16'h0753, 16'h0287, 4'h3, 2'h0, 1'b1, 1'b1);
    wr_q(PDC_ADDR_PARAM + 16'h5, 1, 48'h00);
    cfg_chk(16'h0753, 16'h0287, 4'h3, 2'h0, 1'b1, 1'b1);
    // full word with reserved bits set
    wr_word(48'h007d_000c_a5ff);
    cfg_chk(16'h007d, 16'h000c, 4'h4, 2'h2, 1'b1, 1'b1);
    rd_chk("den high", PDC_ADDR_PARAM, 8'h00);
    rd_chk("num low", PDC_ADDR_PARAM + 16'h3, 8'h0c);
    rd_chk("mid byte", PDC_ADDR_PARAM + 16'h4, 8'h25);
    rd_chk("lock byte", PDC_ADDR_PARAM + 16'h5, 8'h03);
    // every predivider code in integer mode, twelve spaced reference strobes
    for (int c = 0; c < 4; c++) begin
      wr_word({32'h0001_0000, 1'b0, 4'h2, 2'(c), 1'b0, 8'h01});
      @(negedge clk_i);
      chk("int ratio", 48'(fb_ratio_o), 48'h2);
      hits = 0;
      for (int i = 0; i < 24; i++) begin
        ref_tick_i = (i % 2 == 0);
        @(negedge clk_i);
        hits = hits + int'(ref_div_tick_o === 1'b1);
      end
      ref_tick_i = 1'b0;
      repeat (3) begin
        @(negedge clk_i);
        hits = hits + int'(ref_div_tick_o === 1'b1);
      end
      chk("prediv ticks", 48'(hits), 48'(12 / (c + 1)));
    end
    // fractional mode: ratio 3 + 1/4, one long cycle in four
    wr_word({16'h0004, 16'h0001, 1'b0, 4'h3, 2'h0, 1'b1, 8'h01});
    hits = 0;
    for (int i = 0; i < 8; i++) begin
      fb_tick_i = 1'b1;
      @(negedge clk_i);
      fb_tick_i = 1'b0;
      @(negedge clk_i);
      hits = hits + int'(fb_ratio_o === 5'h4);
    end
    chk("long cycles", 48'(hits), 48'h2);
    // disable clears lock; written lock and reserved bits have no effect
    wr_word({32'h0, 1'b0, 4'h3, 2'h0, 1'b0, 8'hfe});
    repeat (3) @(negedge clk_i);
    chk("enable off", 48'(synth_cfg_o.enable), 48'h0);
    rd_chk("lock off", PDC_ADDR_PARAM + 16'h5, 8'h00);
    wr_word({32'h0, 1'b0, 4'h3, 2'h0, 1'b0, 8'h01});
    rd_chk("no lock yet", PDC_ADDR_PARAM + 16'h5, 8'h01);
    lock_detect_i = 1'b1;
    repeat (2) @(negedge clk_i);
    lock_detect_i = 1'b0;
    repeat (3) @(negedge clk_i);
    rd_chk("sticky lock", PDC_ADDR_PARAM + 16'h5, 8'h03);
    // regulator level and an unmapped address
    wr_q(PDC_ADDR_REG, 1, 48'hff);
    chk("supply", 48'(core_supply_output_o), 48'h3);
    rd_chk("regulator", PDC_ADDR_REG, 8'h06);
    wr_q(16'h4008, 1, 48'h55);
    rd_chk("unmapped", 16'h4008, 8'h00);
    chk("core div", 48'(core_div_o), 48'h4);
    end_of_test();
  end

endmodule : pdc_top_bench
